// >>> logic/msd_pkg.sv
// Contract
// - lower select on hits, size up to 512K
// - each region is 8-bit or 16-bit wide
// - bus hold releases selects and strobes
// - straps sampled at reset release, both low
// - test mode floats every pin until reset
// - shared pin is lower select or row strobe
// - whole-range mode frees three midrange pins
// - otherwise each select covers its own region; pins 1-2 become column strobes with any dram bank, pin 3 the upper row strobe with upper dram
// - high column strobe on upper byte access
// - low column strobe on lower byte access
// - refresh start asserts both column strobes
// - upper row strobe negates upper select
package msd_pkg;
    localparam int          ADDR_W        = 20;
    localparam logic [19:0] LOWER_MAX_SZ  = 20'h80000; // 512 Kbytes
    localparam int          MID_REGIONS   = 4;
    localparam logic [1:0]  PINUSE_SELECT = 2'h0;      // midrange pin keeps select
    localparam logic [1:0]  PINUSE_GPIO   = 2'h1;      // midrange pin is general io
    localparam logic [1:0]  PINUSE_DRAM   = 2'h2;      // midrange pin is dram strobe
    localparam int          SYNC_STAGES   = 3;
endpackage : msd_pkg

// >>> logic/msd_select_strobes.sv
`timescale 1ns/1ps
`default_nettype none
module msd_select_strobes (
    input  wire logic        clock,              // 20 MHz bus clock
    input  wire logic        sys_rst,            // async reset, active high
    input  wire logic        reset_in_n,         // device reset pin, straps taken on its rise
    input  wire logic        float_strap_0,      // test-mode strap 0 (pin)
    input  wire logic        float_strap_1,      // test-mode strap 1 (pin)
    input  wire logic        bus_hold,           // hold granted, same clock
    input  wire logic        access_valid,       // bus access in progress
    input  wire logic [19:0] access_addr,        // access address
    input  wire logic        access_high_byte,   // access includes upper data byte
    input  wire logic        access_low_byte,    // access includes lower data byte
    input  wire logic        refresh_start,      // start of a dram refresh access
    input  wire logic [19:0] lower_base,         // lower region base
    input  wire logic [19:0] lower_size,         // lower region size
    input  wire logic        lower_is_dram,      // lower pin is row strobe
    input  wire logic        upper_is_dram,      // upper row strobe enabled
    input  wire logic        upper_hit,          // access hits upper region
    input  wire logic [19:0] mid_base,           // midrange block base
    input  wire logic [19:0] mid_size,           // midrange block size (region = size/4)
    input  wire logic        mid_whole,          // first select covers whole block
    input  wire logic [5:0]  mid_pin_use,        // use of pins 1..3, two bits each
    input  wire logic        lower_wide_cfg,     // lower region 16-bit
    input  wire logic [3:0]  mid_wide_cfg,       // midrange regions 16-bit
    output logic             lower_region_select,// shared pin level
    output logic             lower_region_oe,    // shared pin drive enable
    output logic [3:0]       mid_select,         // midrange pin levels
    output logic [3:0]       mid_oe,             // midrange pin drive enables
    output logic             upper_region_select,// upper select, active low
    output logic             upper_region_oe,    // upper select drive enable
    output logic             bus_is_16bit,       // current access width
    output logic             all_float_test_mode // strap test mode active
);
    typedef enum logic [1:0] {
        MSD_RESET  = 2'b00,
        MSD_NORMAL = 2'b01,
        MSD_FLOAT  = 2'b10
    } msd_mode_type;

    function automatic logic in_range(input logic [19:0] a, input logic [19:0] b,
                                      input logic [19:0] s);
        logic [20:0] off;
        off = {1'b0, a} - {1'b0, b};
        in_range = (off < {1'b0, s});
    endfunction : in_range

    // three-stage synchronisers on the pin inputs
    logic [2:0] rst_sync, s0_sync, s1_sync;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rst_sync <= 3'h0;
            s0_sync  <= 3'h7;
            s1_sync  <= 3'h7;
        end else begin
            rst_sync <= {rst_sync[1:0], reset_in_n};
            s0_sync  <= {s0_sync[1:0], float_strap_0};
            s1_sync  <= {s1_sync[1:0], float_strap_1};
        end
    end
    // reset pin level counts only when the last two stages agree
    logic rst_agree;
    assign rst_agree = (rst_sync[1] == rst_sync[2]);

    // mode machine: straps caught at reset release
    msd_mode_type mode, next_mode;
    logic         rst_level_q, next_rst_level_q;
    always_comb begin
        next_mode        = mode;
        next_rst_level_q = rst_agree ? rst_sync[2] : rst_level_q;
        case (mode)
            MSD_RESET: begin
                if (rst_agree && rst_sync[2] && !rst_level_q) begin
                    if (!s0_sync[2] && !s1_sync[2])
                        next_mode = MSD_FLOAT;
                    else
                        next_mode = MSD_NORMAL;
                end
            end
            MSD_NORMAL, MSD_FLOAT: begin
                if (rst_agree && !rst_sync[2])
                    next_mode = MSD_RESET;
            end
            default: next_mode = MSD_RESET;
        endcase
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mode        <= MSD_RESET;
            rst_level_q <= 1'b0;
        end else begin
            mode        <= next_mode;
            rst_level_q <= next_rst_level_q;
        end
    end

    // address decode and strobe selection
    logic       lower_hit, mid_any, dram_on, dram_acc, floating;
    logic [1:0] mid_idx;
    logic [19:0] lsize, quarter, moff;
    always_comb begin
        // size clamped to the largest lower block
        lsize    = (lower_size > msd_pkg::LOWER_MAX_SZ) ? msd_pkg::LOWER_MAX_SZ : lower_size;
        quarter  = {2'b00, mid_size[19:2]};
        moff     = access_addr - mid_base;
        lower_hit = access_valid && in_range(access_addr, lower_base, lsize);
        mid_any   = access_valid && in_range(access_addr, mid_base, mid_size);
        mid_idx   = 2'h3;
        if (moff < quarter) mid_idx = 2'h0;
        else if (moff < (quarter << 1)) mid_idx = 2'h1;
        else if (moff < quarter + (quarter << 1)) mid_idx = 2'h2;
        dram_on  = lower_is_dram | upper_is_dram;
        dram_acc = (lower_is_dram & lower_hit) | (upper_is_dram & access_valid & upper_hit);
        floating = (mode != MSD_NORMAL) | bus_hold;
    end

    logic       next_lsel, next_usel, next_w16;
    logic [3:0] next_msel;
    always_comb begin
        next_lsel = 1'b1;
        next_usel = 1'b1;
        next_msel = 4'hF;
        next_w16  = 1'b0;
        // shared lower pin
        if (lower_is_dram)
            next_lsel = ~(lower_hit | refresh_start);
        else
            next_lsel = ~lower_hit;
        if (lower_hit) next_w16 = lower_wide_cfg;
        // midrange selects
        if (mid_any) begin
            if (mid_whole) begin
                next_msel[0] = 1'b0;
                next_w16     = mid_wide_cfg[0];
            end else begin
                next_msel[mid_idx] = 1'b0;
                next_w16           = mid_wide_cfg[mid_idx];
            end
        end
        // freed pins: general io and dram pins both stay high; the strobes below ignore pin use,
        // pins kept as selects still mark their own quarter
        for (int i = 1; i < msd_pkg::MID_REGIONS; i++) begin
            if (mid_whole && mid_pin_use[2*i-2 +: 2] != msd_pkg::PINUSE_SELECT)
                next_msel[i] = 1'b1;
            else if (mid_whole && mid_any && mid_idx == 2'(i))
                next_msel[i] = 1'b0;
        end
        // column strobes serve accesses to either dram bank
        if (dram_on) begin
            next_msel[1] = ~(refresh_start | (dram_acc && access_high_byte));
            next_msel[2] = ~(refresh_start | (dram_acc && access_low_byte));
        end
        if (upper_is_dram) begin
            next_msel[3] = ~((access_valid & upper_hit) | refresh_start);
            next_usel    = 1'b1;
        end else begin
            next_usel = ~(access_valid & upper_hit);
        end
    end

    // output registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lower_region_select <= 1'b1;
            mid_select          <= 4'hF;
            upper_region_select <= 1'b1;
            lower_region_oe     <= 1'b0;
            mid_oe              <= 4'h0;
            upper_region_oe     <= 1'b0;
            bus_is_16bit        <= 1'b0;
            all_float_test_mode <= 1'b0;
        end else begin
            lower_region_select <= next_lsel;
            mid_select          <= next_msel;
            upper_region_select <= next_usel;
            lower_region_oe     <= ~floating;
            mid_oe              <= {4{~floating}};
            upper_region_oe     <= ~floating;
            bus_is_16bit        <= next_w16;
            all_float_test_mode <= (next_mode == MSD_FLOAT);
        end
    end

    // strap capture: agreed rise of the reset pin while still waiting in reset
    sequence strap_rise_s;
        mode == MSD_RESET && rst_agree && rst_sync[2] && !rst_level_q;
    endsequence

    hold_release_a: assert property (@(posedge clock) disable iff (sys_rst)
        bus_hold |=> !lower_region_oe && mid_oe == 4'h0)
        else $error("pins driven during hold");
    float_stays_a: assert property (@(posedge clock) disable iff (sys_rst)
        all_float_test_mode |-> !lower_region_oe && !upper_region_oe && mid_oe == 4'h0)
        else $error("pins driven in test mode");
    float_entry_a: assert property (@(posedge clock) disable iff (sys_rst)
        strap_rise_s ##0 (!s0_sync[2] && !s1_sync[2]) |=> all_float_test_mode)
        else $error("test mode not entered");
    normal_entry_a: assert property (@(posedge clock) disable iff (sys_rst)
        strap_rise_s ##0 (s0_sync[2] || s1_sync[2]) |=> mode == MSD_NORMAL && !all_float_test_mode)
        else $error("normal mode not entered");
    upper_negated_a: assert property (@(posedge clock) disable iff (sys_rst)
        upper_is_dram |=> upper_region_select)
        else $error("upper select active with row strobe");
    upper_row_a: assert property (@(posedge clock) disable iff (sys_rst)
        upper_is_dram && access_valid && upper_hit |=> !mid_select[3])
        else $error("upper row strobe missed");
    refresh_cas_a: assert property (@(posedge clock) disable iff (sys_rst)
        refresh_start && dram_on |=> mid_select[2:1] == 2'b00)
        else $error("refresh missing column strobes");
    high_cas_a: assert property (@(posedge clock) disable iff (sys_rst)
        dram_acc && access_high_byte |=> !mid_select[1])
        else $error("high column strobe missed");
    low_cas_a: assert property (@(posedge clock) disable iff (sys_rst)
        dram_acc && access_low_byte |=> !mid_select[2])
        else $error("low column strobe missed");
    lower_hit_a: assert property (@(posedge clock) disable iff (sys_rst)
        lower_hit && !lower_is_dram |=> !lower_region_select)
        else $error("lower select missed");
    lower_row_a: assert property (@(posedge clock) disable iff (sys_rst)
        lower_hit && lower_is_dram |=> !lower_region_select)
        else $error("lower row strobe missed");
    idle_high_a: assert property (@(posedge clock) disable iff (sys_rst)
        !access_valid && !refresh_start |=> lower_region_select && upper_region_select)
        else $error("select active when idle");
    whole_mid_a: assert property (@(posedge clock) disable iff (sys_rst)
        mid_any && mid_whole |=> !mid_select[0])
        else $error("whole range select missed");
    own_region_a: assert property (@(posedge clock) disable iff (sys_rst)
        mid_any && !mid_whole && mid_idx == 2'h3 && !upper_is_dram |=> !mid_select[3])
        else $error("fourth region select missed");
endmodule : msd_select_strobes
`default_nettype wire

// >>> verif/msd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// board side of the select pins: memories and dram banks behind pull-ups
module msd_mem_model (
    input  wire logic       lower_region_select, // shared pin level
    input  wire logic       lower_region_oe,     // shared pin enable
    input  wire logic [3:0] mid_select,          // midrange pin levels
    input  wire logic [3:0] mid_oe,              // midrange pin enables
    output logic            lower_pin,           // resolved shared pin
    output logic [3:0]      mid_pin              // resolved midrange pins
);
    // released pins are pulled up to the inactive level
    assign lower_pin = lower_region_oe ? lower_region_select : 1'h1;
    assign mid_pin   = (mid_oe & mid_select) | ~mid_oe;
endmodule : msd_mem_model
`default_nettype wire

// >>> verif/tb_msd_select_strobes.sv
`timescale 1ns/1ps
`default_nettype none
module tb_msd_select_strobes;
    logic        clock = 1'h0, sys_rst = 1'h1, reset_in_n = 1'h0, float_strap_0 = 1'h1;
    logic        float_strap_1 = 1'h1, bus_hold = 1'h0, access_valid = 1'h0;
    logic        access_high_byte = 1'h1, access_low_byte = 1'h1, refresh_start = 1'h0;
    logic        lower_is_dram = 1'h0, upper_is_dram = 1'h0, upper_hit = 1'h0;
    logic        mid_whole = 1'h0, lower_wide_cfg = 1'h1, lower_pin;
    logic [19:0] access_addr = 20'h00000, lower_base = 20'h00000, lower_size = 20'h80000;
    logic [19:0] mid_base = 20'h80000, mid_size = 20'h40000;
    logic [5:0]  mid_pin_use = 6'h00;
    logic [3:0]  mid_wide_cfg = 4'h5, mid_select, mid_oe, mid_pin;
    logic        lower_region_select, lower_region_oe, upper_region_select, upper_region_oe;
    logic        bus_is_16bit, all_float_test_mode;
    int          errors = 0, n_tests = 0;
    // bus clock
    always #25 clock = ~clock;
    msd_select_strobes i_dut (.clock, .sys_rst, .reset_in_n, .float_strap_0, .float_strap_1,
        .bus_hold, .access_valid, .access_addr, .access_high_byte, .access_low_byte,
        .refresh_start, .lower_base, .lower_size, .lower_is_dram, .upper_is_dram, .upper_hit,
        .mid_base, .mid_size, .mid_whole, .mid_pin_use, .lower_wide_cfg, .mid_wide_cfg,
        .lower_region_select, .lower_region_oe, .mid_select, .mid_oe, .upper_region_select,
        .upper_region_oe, .bus_is_16bit, .all_float_test_mode);
    msd_mem_model i_mem (.lower_region_select, .lower_region_oe, .mid_select, .mid_oe,
        .lower_pin, .mid_pin);
    // compare one result, up to four bits
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    // one access cycle, outputs seen one edge later
    task automatic acc(input logic [19:0] a, input logic hb, input logic lb);
        access_valid = 1'h1;
        access_addr = a;
        access_high_byte = hb;
        access_low_byte = lb;
        cyc(1);
    endtask : acc
    // device reset with the straps held at s
    task automatic boot(input logic [1:0] s);
        sys_rst = 1'h1;
        reset_in_n = 1'h0;
        {float_strap_1, float_strap_0} = s;
        cyc(5);
        sys_rst = 1'h0;
        cyc(2);
        reset_in_n = 1'h1;
        cyc(6);
        {float_strap_1, float_strap_0} = 2'h3;
        acc(20'h00010, 1'h1, 1'h1);
    endtask : boot
    task automatic t_strap;
        for (int s = 0; s < 4; s++) begin
            boot(2'(s));
            cyc(3);
            chk(all_float_test_mode, 4'(s == 0));
            chk({lower_region_oe, lower_pin}, s == 0 ? 4'h1 : 4'h2);
        end
        $display("strap test done");
    endtask : t_strap
    task automatic t_lower;
        acc(20'h7FFFF, 1'h1, 1'h1);
        chk(lower_region_select, 4'h0);
        chk(bus_is_16bit, 4'h1);
        lower_wide_cfg = 1'h0;
        acc(20'h00000, 1'h1, 1'h1);
        chk(bus_is_16bit, 4'h0);
        acc(20'h80000, 1'h1, 1'h1);
        chk({lower_region_select, mid_select[0]}, 4'h2);
        acc(20'hC0000, 1'h1, 1'h1);
        chk(mid_select, 4'hF);
        $display("lower test done");
    endtask : t_lower
    task automatic t_mid;
        for (int k = 0; k < 4; k++) begin
            acc(20'h8FFFF + 20'(k) * 20'h10000, 1'h1, 1'h1);
            chk(mid_select, ~(4'h1 << k));
            chk(bus_is_16bit, mid_wide_cfg[k]);
        end
        mid_whole = 1'h1;
        acc(20'hB0000, 1'h1, 1'h1);
        chk(mid_select, 4'h6);
        mid_pin_use = 6'h15;
        acc(20'hB0000, 1'h1, 1'h1);
        chk(mid_select, 4'hE);
        $display("midrange test done");
    endtask : t_mid
    task automatic t_dram;
        mid_pin_use = 6'h2A;
        lower_is_dram = 1'h1;
        acc(20'h00100, 1'h1, 1'h0);
        chk({lower_region_select, mid_select[2:1]}, 4'h2);
        acc(20'h00100, 1'h0, 1'h1);
        chk(mid_select[2:1], 4'h1);
        access_valid = 1'h0;
        refresh_start = 1'h1;
        cyc(1);
        refresh_start = 1'h0;
        chk(mid_select[2:1], 4'h0);
        upper_hit = 1'h1;
        for (int u = 0; u < 2; u++) begin
            upper_is_dram = 1'(u);
            acc(20'hF0000, 1'h1, 1'h1);
            chk(upper_region_select, 4'(u));
            chk(mid_select, u == 1 ? 4'h1 : 4'hF);
        end
        $display("dram test done");
    endtask : t_dram
    task automatic t_hold;
        acc(20'h00200, 1'h1, 1'h1);
        bus_hold = 1'h1;
        cyc(1);
        chk(mid_oe, 4'h0);
        chk({lower_region_oe, upper_region_oe, lower_pin, mid_pin[3]}, 4'h3);
        bus_hold = 1'h0;
        cyc(1);
        chk(lower_pin, 4'h0);
        $display("hold test done");
    endtask : t_hold
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    // main sequence
    initial begin
        t_strap();
        t_lower();
        t_mid();
        t_dram();
        t_hold();
        print_verdict();
    end
    // watchdog, far beyond the 86 cycles the tests need
    initial begin
        #(2000 * 50);
        errors++;
        print_verdict();
    end
endmodule : tb_msd_select_strobes
`default_nettype wire
